/* File: verilog/pax_aux_regs.sv */
`timescale 1ns/1ns
module pax_aux_regs (
	input  wire logic            hclk,
	input  wire logic            hresetn,
	input  wire logic            hsel,
	input  wire logic [31:0]     haddr,
	input  wire logic [1:0]      htrans,
	input  wire logic            hwrite,
	input  wire logic [2:0]      hsize,
	input  wire logic [31:0]     hwdata,
	input  wire logic            hready,
	output logic      [31:0]     hrdata,
	output logic                 hreadyout,
	output logic                 hresp,
	input  wire pax_pkg::pax_fiber_in_t fiber_in,
	output pax_pkg::pax_phase_cmd_t     tx_phase,
	output logic      [2:0]      power_back_off_level,
	output logic                 regulator_power_down,
	output logic      [3:0]      regulator_control_value,
	output logic                 fiber_sd_effective,
	output logic                 irq
);
	import pax_pkg::*;

	// ****************************************************************
	// State.
	// ****************************************************************
	typedef struct packed {
		pax_bus_st_t             bus_st;
		logic [IDX_W-1:0]        idx;
		logic                    write;
		logic [31:0]             rdata;
		logic [PH_W-1:0]         phase;
		logic                    shift_pulse;
		logic signed [7:0]       delta_ns;
		logic [PBO_W-1:0]        pbo;
		logic                    reg_pd;
		logic [REG_RSV_W-1:0]    reg_rsv;
		logic [REG_CTRL_W-1:0]   reg_ctrl;
		logic                    fef_lh;
		logic                    pecl_lh;
		logic                    sd_ll;
		logic                    auto_en;
		logic                    man_en;
		logic                    man_val;
		logic                    fef_prev;
		logic                    pecl_prev;
		logic                    sd_prev;
		logic                    sd_eff;
		logic [IRQ_W-1:0]        irq_stat;
		logic [IRQ_W-1:0]        irq_mask;
		logic                    irq;
	} pax_regs_t;

	pax_regs_t     st_r;
	pax_regs_t     st_nxt;
	pax_fiber_in_t fib_s;

	// ****************************************************************
	// Fiber inputs arrive from the optical side and are synchronised.
	// ****************************************************************
	pax_sync #(
		.W ($bits(pax_fiber_in_t))
	) i_pax_sync (
		.hclk    (hclk),
		.hresetn (hresetn),
		.d       (fiber_in),
		.q       (fib_s)
	);

	logic                 accept;
	logic                 wr_fire;
	logic                 rd_fire;
	logic [PH_W-1:0]      ph_new;
	logic signed [7:0]    ph_diff;
	logic [15:0]          rd_word;
	logic [IRQ_W-1:0]     irq_ev;

	// ****************************************************************
	// Bus decode.
	// ****************************************************************
	// Every transfer takes one wait state so that read data comes from a flop.
	assign accept  = hsel && (htrans == HTRANS_NONSEQ || htrans[1]) && hready;
	assign wr_fire = (st_r.bus_st == PAX_BUS_WAIT) && st_r.write;
	assign rd_fire = (st_r.bus_st == PAX_BUS_WAIT) && !st_r.write;

	always_comb begin
		rd_word = 16'h0000;
		if (st_r.idx == IDX_TX_PHASE) begin
			rd_word = {12'h000, st_r.phase};
		end else if (st_r.idx == IDX_PWR_BO) begin
			rd_word = PBO_FIXED | {7'h00, st_r.pbo, 6'h00};
		end else if (st_r.idx == IDX_REG_CTRL) begin
			rd_word = {1'b0, st_r.reg_rsv, st_r.reg_ctrl};
		end else if (st_r.idx == IDX_FIB_CTRL2) begin
			rd_word = FIB2_FIXED;
			rd_word[FIB_FEF_BIT]  = st_r.fef_lh;
			rd_word[FIB_PECL_BIT] = st_r.pecl_lh;
			rd_word[FIB_SD_BIT]   = st_r.sd_ll;
			rd_word[FIB_AUTO_BIT] = st_r.auto_en;
		end else if (st_r.idx == IDX_FIB_MANUAL) begin
			rd_word = MAN_FIXED;
			rd_word[MAN_EN_BIT]  = st_r.man_en;
			rd_word[MAN_VAL_BIT] = st_r.man_val;
		end else if (st_r.idx == IDX_IRQ_STATUS) begin
			rd_word = {12'h000, st_r.irq_stat};
		end else if (st_r.idx == IDX_IRQ_MASK) begin
			rd_word = {12'h000, st_r.irq_mask};
		end
	end

	// Values above the top step wrap by subtracting ten once, which covers 11 to 15.
	assign ph_new  = (hwdata[PH_LSB +: PH_W] > PH_MAX) ?
		4'(hwdata[PH_LSB +: PH_W] - PH_MAX) : hwdata[PH_LSB +: PH_W];
	assign ph_diff = $signed({4'h0, ph_new}) - $signed({4'h0, st_r.phase});

	always_comb begin
		irq_ev              = '0;
		irq_ev[IRQ_FEF]     = fib_s.fef && !st_r.fef_prev;
		irq_ev[IRQ_PECL]    = fib_s.pecl_violation && !st_r.pecl_prev;
		irq_ev[IRQ_SD_LOSS] = !fib_s.signal_detect && st_r.sd_prev;
		irq_ev[IRQ_PHASE]   = st_r.shift_pulse;
	end

	// ****************************************************************
	// Next state.
	// ****************************************************************
	always_comb begin
		st_nxt             = st_r;
		st_nxt.shift_pulse = 1'b0;
		st_nxt.fef_prev    = fib_s.fef;
		st_nxt.pecl_prev   = fib_s.pecl_violation;
		st_nxt.sd_prev     = fib_s.signal_detect;

		case (st_r.bus_st)
			PAX_BUS_IDLE, PAX_BUS_DONE: begin
				if (accept) begin
					st_nxt.bus_st = PAX_BUS_WAIT;
					st_nxt.idx    = haddr[IDX_W+1:2];
					st_nxt.write  = hwrite;
				end else begin
					st_nxt.bus_st = PAX_BUS_IDLE;
				end
			end
			PAX_BUS_WAIT: begin
				st_nxt.bus_st = PAX_BUS_DONE;
			end
			default: begin
				st_nxt.bus_st = PAX_BUS_IDLE;
			end
		endcase

		// The read answer is held until the next read; unmapped words read zero.
		if (rd_fire) begin
			st_nxt.rdata = {16'h0000, rd_word};
		end

		// Latched-high bits follow the event; a read drops them to the live level.
		if (rd_fire && st_r.idx == IDX_FIB_CTRL2) begin
			st_nxt.fef_lh  = fib_s.fef;
			st_nxt.pecl_lh = fib_s.pecl_violation;
			st_nxt.sd_ll   = fib_s.signal_detect;
		end else begin
			st_nxt.fef_lh  = st_r.fef_lh | fib_s.fef;
			st_nxt.pecl_lh = st_r.pecl_lh | fib_s.pecl_violation;
			st_nxt.sd_ll   = st_r.sd_ll & fib_s.signal_detect;
		end

		// A new event in the clearing read cycle still sets its status bit.
		if (rd_fire && st_r.idx == IDX_IRQ_STATUS) begin
			st_nxt.irq_stat = irq_ev;
		end else begin
			st_nxt.irq_stat = st_r.irq_stat | irq_ev;
		end

		if (wr_fire) begin
			if (st_r.idx == IDX_TX_PHASE) begin
				if (hwdata[PH_EN_BIT]) begin
					st_nxt.phase       = ph_new;
					st_nxt.shift_pulse = 1'b1;
					st_nxt.delta_ns    = ph_diff * PH_STEP_NS;
				end
			end else if (st_r.idx == IDX_PWR_BO) begin
				st_nxt.pbo = hwdata[PBO_LSB +: PBO_W];
			end else if (st_r.idx == IDX_REG_CTRL) begin
				st_nxt.reg_pd   = hwdata[REG_PD_BIT];
				st_nxt.reg_rsv  = hwdata[REG_RSV_LSB +: REG_RSV_W];
				st_nxt.reg_ctrl = hwdata[REG_CTRL_W-1:0];
			end else if (st_r.idx == IDX_FIB_CTRL2) begin
				st_nxt.auto_en = hwdata[FIB_AUTO_BIT];
			end else if (st_r.idx == IDX_FIB_MANUAL) begin
				st_nxt.man_en  = hwdata[MAN_EN_BIT];
				st_nxt.man_val = hwdata[MAN_VAL_BIT];
			end else if (st_r.idx == IDX_IRQ_MASK) begin
				st_nxt.irq_mask = hwdata[IRQ_W-1:0];
			end
		end

		// Manual level wins, then auto detection from valid signalling, then the pin.
		if (st_r.man_en) begin
			st_nxt.sd_eff = st_r.man_val;
		end else if (st_r.auto_en) begin
			st_nxt.sd_eff = fib_s.valid_signalling;
		end else begin
			st_nxt.sd_eff = fib_s.signal_detect;
		end

		st_nxt.irq = |(st_r.irq_stat & st_r.irq_mask);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r          <= '0;
			st_r.bus_st   <= PAX_BUS_IDLE;
			st_r.phase    <= PH_RST;
			st_r.pbo      <= PBO_RST;
			st_r.rdata    <= WORD_ZERO;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ****************************************************************
	// Outputs.
	// ****************************************************************
	assign hreadyout               = (st_r.bus_st != PAX_BUS_WAIT);
	assign hresp                   = 1'b0;
	assign hrdata                  = st_r.rdata;
	assign tx_phase.shift_pulse    = st_r.shift_pulse;
	assign tx_phase.delta_ns       = st_r.delta_ns;
	assign tx_phase.value          = st_r.phase;
	assign power_back_off_level    = st_r.pbo;
	// The bit reads back as zero, but the regulator stays off until it is written 0.
	assign regulator_power_down    = st_r.reg_pd;
	// Reserved regulator bits are stored as written; software keeps them zero.
	assign regulator_control_value = st_r.reg_ctrl;
	assign fiber_sd_effective      = st_r.sd_eff;
	assign irq                     = st_r.irq;

	// ****************************************************************
	// Assertions.
	// ****************************************************************
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	logic wr_phase_en;
	logic rd_fib2;
	assign wr_phase_en = wr_fire && st_r.idx == IDX_TX_PHASE && hwdata[PH_EN_BIT];
	assign rd_fib2     = rd_fire && st_r.idx == IDX_FIB_CTRL2;

	AST_PHASE_RANGE: assert property (st_r.phase <= PH_MAX)
		else $error("phase value above ten");
	AST_PHASE_MOD: assert property (wr_phase_en && hwdata[3:0] > PH_MAX |=>
		st_r.phase == 4'($past(hwdata[3:0]) - PH_MAX))
		else $error("phase not wrapped modulo ten");
	AST_PHASE_DELTA: assert property (st_r.shift_pulse |->
		st_r.delta_ns == 8'(($signed({4'h0, st_r.phase}) -
		$signed({4'h0, $past(st_r.phase)})) * PH_STEP_NS))
		else $error("phase step not four ns per count");
	AST_PHASE_HOLD: assert property (wr_fire && st_r.idx == IDX_TX_PHASE &&
		!hwdata[PH_EN_BIT] |=> $stable(st_r.phase) && !st_r.shift_pulse)
		else $error("phase moved without enable");
	AST_PHASE_READ: assert property (rd_fire && st_r.idx == IDX_TX_PHASE |=>
		hrdata[3:0] == $past(st_r.phase) && hrdata[15:4] == 12'h000)
		else $error("phase readback wrong");
	AST_PBO: assert property (wr_fire && st_r.idx == IDX_PWR_BO |=>
		power_back_off_level == $past(hwdata[8:6]))
		else $error("power back-off not taken");
	AST_REG_PD: assert property (wr_fire && st_r.idx == IDX_REG_CTRL &&
		hwdata[REG_PD_BIT] |=> regulator_power_down [*2])
		else $error("regulator not powered down");
	AST_FEF_HOLD: assert property (st_r.fef_lh && !rd_fib2 |=> st_r.fef_lh)
		else $error("far-end fault bit dropped");
	AST_PECL_SET: assert property (fib_s.pecl_violation |=> st_r.pecl_lh)
		else $error("signalling status not set");
	AST_SD_LATCH: assert property (!fib_s.signal_detect && !rd_fib2 |=>
		!st_r.sd_ll)
		else $error("signal detect not latched low");
	AST_AUTO_SD: assert property (!st_r.man_en && st_r.auto_en &&
		fib_s.valid_signalling |=> fiber_sd_effective)
		else $error("auto signal detect failed");
	AST_MANUAL_SD: assert property (st_r.man_en |=>
		fiber_sd_effective == $past(st_r.man_val))
		else $error("manual signal detect not obeyed");
	AST_READ_LIVE: assert property (rd_fib2 |=> st_r.fef_lh == $past(fib_s.fef) &&
		st_r.pecl_lh == $past(fib_s.pecl_violation))
		else $error("status not refreshed by read");
	AST_BUS_WAIT: assert property (accept && hreadyout |=> !hreadyout ##1 hreadyout)
		else $error("wait state missing");

	// ****************************************************************
	// Further checks on registers, fiber status, interrupts and the bus.
	// ****************************************************************
	// The enable pulse is one cycle wide, so a phase write never shifts twice.
	AST_PHASE_PULSE_ONE: assert property (st_r.shift_pulse |=> !st_r.shift_pulse)
		else $error("phase shift pulse longer than one cycle");
	AST_PHASE_KEEP: assert property (!wr_fire |=> $stable(st_r.phase))
		else $error("phase changed without a write");
	AST_PHASE_SMALL: assert property (wr_phase_en &&
		hwdata[PH_LSB +: PH_W] <= PH_MAX |=> st_r.phase == $past(hwdata[PH_LSB +: PH_W]))
		else $error("valid phase value not taken as written");
	AST_PBO_READ: assert property (rd_fire && st_r.idx == IDX_PWR_BO |=>
		hrdata[PBO_LSB +: PBO_W] == $past(st_r.pbo))
		else $error("power back-off readback wrong");
	AST_PBO_KEEP: assert property (!(wr_fire && st_r.idx == IDX_PWR_BO) |=>
		$stable(power_back_off_level))
		else $error("power back-off moved without a write");
	AST_REG_PD_OFF: assert property (wr_fire && st_r.idx == IDX_REG_CTRL &&
		!hwdata[REG_PD_BIT] |=> !regulator_power_down)
		else $error("regulator not kept powered");
	AST_REG_PD_SC: assert property (rd_fire && st_r.idx == IDX_REG_CTRL |=>
		!hrdata[REG_PD_BIT])
		else $error("power-down bit did not read back clear");
	AST_FEF_SET: assert property (fib_s.fef |=> st_r.fef_lh)
		else $error("far-end fault bit not set");
	AST_PECL_HOLD: assert property (st_r.pecl_lh && !rd_fib2 |=> st_r.pecl_lh)
		else $error("signalling status bit dropped");
	AST_SD_REFRESH: assert property (rd_fib2 |=>
		st_r.sd_ll == $past(fib_s.signal_detect))
		else $error("signal detect not refreshed by read");
	AST_SD_LOW_HOLD: assert property (!st_r.sd_ll && !rd_fib2 |=> !st_r.sd_ll)
		else $error("latched-low signal detect rose without a read");
	AST_FIB2_READ: assert property (rd_fib2 |=>
		hrdata[FIB_FEF_BIT] == $past(st_r.fef_lh) &&
		hrdata[FIB_PECL_BIT] == $past(st_r.pecl_lh) &&
		hrdata[FIB_SD_BIT] == $past(st_r.sd_ll))
		else $error("fiber status readback wrong");
	AST_AUTO_SD_OFF: assert property (!st_r.man_en && st_r.auto_en &&
		!fib_s.valid_signalling |=> !fiber_sd_effective)
		else $error("auto signal detect without valid signalling");
	AST_PIN_SD: assert property (!st_r.man_en && !st_r.auto_en |=>
		fiber_sd_effective == $past(fib_s.signal_detect))
		else $error("signal detect does not follow the input");
	AST_MANUAL_OVER: assert property (st_r.man_en && !st_r.man_val &&
		st_r.auto_en && fib_s.valid_signalling |=> !fiber_sd_effective)
		else $error("auto detection overrode the manual level");
	// Interrupt status is sticky, and an event wins over a clearing read in the same cycle.
	AST_IRQ_SET_WINS: assert property (irq_ev != '0 |=>
		(st_r.irq_stat & $past(irq_ev)) == $past(irq_ev))
		else $error("interrupt event lost");
	AST_IRQ_ON: assert property ((st_r.irq_stat & st_r.irq_mask) != '0 |=> irq)
		else $error("interrupt not raised");
	AST_IRQ_OFF: assert property ((st_r.irq_stat & st_r.irq_mask) == '0 |=> !irq)
		else $error("interrupt raised without cause");
	AST_HRDATA_HOLD: assert property (!rd_fire |=> $stable(hrdata))
		else $error("read data changed without a read");
	AST_WAIT_ONE: assert property (!hreadyout |=> hreadyout)
		else $error("more than one wait state");
endmodule

/* File: verilog/pax_pkg.sv */
// Operation
// - The transmit clock phase value counts in 4 ns steps and is valid from 0 to 10.
// - A written phase value above 10 is stored and applied as the value modulo 10.
// - A phase update moves the transmit clock by 4 ns times the new value minus the old value.
// - Writing 1 to the self-clearing enable bit applies the phase value, and writing 0 leaves it.
// - The 4-bit phase field reads back the current phase offset and resets to zero.
// - The 3-bit power back-off field selects normal, level 1, level 2 or level 3 transmit power.
// - Setting the self-clearing power-down bit powers the regulator down, and clearing it keeps it on.
// - The far-end fault status bit is set and held high when far-end fault signalling is seen.
// - The optical signalling status bit is set and held high when invalid signalling is seen.
// - The signal-detect status bit latches low on loss of signal detect, and a read refreshes it.
// - With auto signal detect enabled, valid signalling counts as signal detect and brings the link up.
// - Manual signal-detect configuration overrides every other signal-detect mechanism.
package pax_pkg;

	// ****************************************************************
	// Register indices; the byte address is four times the index.
	// ****************************************************************
	localparam int             IDX_W           = 10;
	localparam logic [9:0]     IDX_TX_PHASE    = 10'h042;
	localparam logic [9:0]     IDX_PWR_BO      = 10'h0ae;
	localparam logic [9:0]     IDX_REG_CTRL    = 10'h0d0;
	localparam logic [9:0]     IDX_FIB_CTRL2   = 10'h0fd;
	localparam logic [9:0]     IDX_FIB_MANUAL  = 10'h102;
	localparam logic [9:0]     IDX_IRQ_STATUS  = 10'h1f0;
	localparam logic [9:0]     IDX_IRQ_MASK    = 10'h1f1;

	// ****************************************************************
	// Field layouts and fixed read values.
	// ****************************************************************
	localparam int             PH_LSB          = 0;
	localparam int             PH_W            = 4;
	localparam int             PH_EN_BIT       = 4;
	localparam logic [3:0]     PH_MAX          = 4'ha;
	localparam logic [3:0]     PH_RST          = 4'h0;
	localparam logic signed [7:0] PH_STEP_NS   = 8'sh04;
	localparam int             PBO_LSB         = 6;
	localparam int             PBO_W           = 3;
	localparam logic [2:0]     PBO_RST         = 3'h0;
	localparam logic [15:0]    PBO_FIXED       = 16'h8020;
	localparam int             REG_PD_BIT      = 15;
	localparam int             REG_RSV_LSB     = 4;
	localparam int             REG_RSV_W       = 11;
	localparam int             REG_CTRL_W      = 4;
	localparam int             FIB_FEF_BIT     = 15;
	localparam int             FIB_PECL_BIT    = 14;
	localparam int             FIB_SD_BIT      = 13;
	localparam int             FIB_AUTO_BIT    = 9;
	localparam logic [15:0]    FIB2_FIXED      = 16'h0d64;
	localparam int             MAN_EN_BIT      = 15;
	localparam int             MAN_VAL_BIT     = 14;
	localparam logic [15:0]    MAN_FIXED       = 16'h0200;
	localparam int             IRQ_W           = 4;
	localparam int             IRQ_FEF         = 0;
	localparam int             IRQ_PECL        = 1;
	localparam int             IRQ_SD_LOSS     = 2;
	localparam int             IRQ_PHASE       = 3;
	localparam logic [1:0]     HTRANS_NONSEQ   = 2'h2;
	localparam logic [31:0]    WORD_ZERO       = 32'h0000_0000;

	// ****************************************************************
	// Types.
	// ****************************************************************
	typedef enum logic [1:0] {
		PAX_BUS_IDLE = 2'h0,
		PAX_BUS_WAIT = 2'h1,
		PAX_BUS_DONE = 2'h3
	} pax_bus_st_t;

	typedef struct packed {
		logic fef;
		logic pecl_violation;
		logic signal_detect;
		logic valid_signalling;
	} pax_fiber_in_t;

	typedef struct packed {
		logic              shift_pulse;
		logic signed [7:0] delta_ns;
		logic [3:0]        value;
	} pax_phase_cmd_t;

endpackage

/* File: verilog/pax_sync.sv */
`timescale 1ns/1ns
module pax_sync #(
	parameter int W = 1
) (
	input  wire logic         hclk,
	input  wire logic         hresetn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
	} pax_sync_st_t;

	pax_sync_st_t st_r;
	pax_sync_st_t st_nxt;

	// The first stage feeds only the second stage, never any logic.
	always_comb begin
		st_nxt      = st_r;
		st_nxt.meta = d;
		st_nxt.sync = st_r.meta;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign q = st_r.sync;
endmodule

/* File: testbench/tb_pax_aux_regs.sv */
`timescale 1ns/1ns
module tb_pax_aux_regs;
	import pax_pkg::*;

	// ****************************************************************
	// Bench signals.
	// ****************************************************************
	logic                hclk;
	logic                hresetn;
	logic                hsel;
	logic [31:0]         haddr;
	logic [1:0]          htrans;
	logic                hwrite;
	logic [2:0]          hsize;
	logic [31:0]         hwdata;
	logic                hready;
	logic [31:0]         hrdata;
	logic                hreadyout;
	logic                hresp;
	pax_fiber_in_t       fiber_in;
	pax_phase_cmd_t      tx_phase;
	pax_phase_cmd_t      cap_phase;
	logic [2:0]          power_back_off_level;
	logic                regulator_power_down;
	logic [3:0]          regulator_control_value;
	logic                fiber_sd_effective;
	logic                irq;
	logic [31:0]         rd;
	logic                resp;
	int                  err_total;
	int                  n_compared;
	logic [15:0]         ph_wr  [5] = '{16'h0019, 16'h001d, 16'h000a, 16'h001a, 16'h001f};
	logic [3:0]          ph_val [5] = '{4'h9, 4'h3, 4'h3, 4'ha, 4'h5};
	logic [7:0]          ph_dns [5] = '{8'h24, 8'he8, 8'he8, 8'h1c, 8'hec};

	// One slave on the bus, so its own ready closes the loop.
	assign hready = hreadyout;

	pax_aux_regs i_pax_aux_regs (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .fiber_in(fiber_in),
		.tx_phase(tx_phase), .power_back_off_level(power_back_off_level),
		.regulator_power_down(regulator_power_down),
		.regulator_control_value(regulator_control_value),
		.fiber_sd_effective(fiber_sd_effective), .irq(irq)
	);

	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	// ****************************************************************
	// Checking and bus tasks.
	// ****************************************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp);
		chk({31'h0000_0000, got}, {31'h0000_0000, exp});
	endtask

	// Ready and read data come from flops, so their level in the low half of the clock is
	// what the next rising edge samples; reading them at the edge itself would race the slave.
	task automatic wait_rdy();
		int   n;
		logic ok;
		n  = 0;
		ok = 1'b0;
		do begin
			@(negedge hclk);
			ok        = (hreadyout === 1'b1);
			rd        = hrdata;
			resp      = hresp;
			cap_phase = tx_phase;
			@(posedge hclk);
			n++;
		end while (!ok && n < 50);
		if (!ok) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, ok, 1'b1);
		end
	endtask

	// The master only moves right after an edge and waits for ready, never a fixed count.
	task automatic bus(input logic wr_en, input logic [9:0] idx, input logic [15:0] wd);
		hsel   <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		hwrite <= wr_en;
		hsize  <= 3'h2;
		haddr  <= {20'h0_0000, idx, 2'h0};
		wait_rdy();
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {16'h0000, wd};
		wait_rdy();
		chk1(resp, 1'b0);
	endtask

	task automatic wr(input logic [9:0] idx, input logic [15:0] d);
		bus(1'b1, idx, d);
	endtask

	task automatic rchk(input logic [9:0] idx, input logic [15:0] e);
		bus(1'b0, idx, 16'h0000);
		chk(rd, {16'h0000, e});
	endtask

	// Fiber inputs pass a two-flop synchroniser, so give them time to land.
	task automatic settle();
		repeat (6) @(posedge hclk);
	endtask

	task automatic results();
		$display("Comparisons %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	initial begin
		#100000;
		err_total++;
		results();
	end

	// ****************************************************************
	// Test sequence.
	// ****************************************************************
	initial begin
		err_total = 0;
		n_compared = 0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
		fiber_in = '{fef: 1'b0, pecl_violation: 1'b0, signal_detect: 1'b1,
			valid_signalling: 1'b0};
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		settle();
		rchk(IDX_TX_PHASE, 16'h0000);
		rchk(IDX_PWR_BO, PBO_FIXED);
		rchk(IDX_REG_CTRL, 16'h0000);
		rchk(IDX_FIB_MANUAL, MAN_FIXED);
		rchk(IDX_IRQ_MASK, 16'h0000);
		rchk(10'h3ff, 16'h0000);
		chk1(regulator_power_down, 1'b0);
		for (int i = 0; i < 5; i++) begin
			wr(IDX_TX_PHASE, ph_wr[i]);
			chk1(cap_phase.shift_pulse, ph_wr[i][4]);
			chk({24'h00_0000, cap_phase.delta_ns}, {24'h00_0000, ph_dns[i]});
			rchk(IDX_TX_PHASE, {12'h000, ph_val[i]});
			chk({28'h000_0000, tx_phase.value}, {28'h000_0000, ph_val[i]});
			chk1(tx_phase.shift_pulse, 1'b0);
		end
		for (int l = 0; l < 4; l++) begin
			wr(IDX_PWR_BO, 16'(l << 6));
			rchk(IDX_PWR_BO, PBO_FIXED | 16'(l << 6));
			chk({29'h0000_0000, power_back_off_level}, 32'(l));
		end
		bus(1'b0, IDX_REG_CTRL, 16'h0000);
		wr(IDX_REG_CTRL, 16'h8005);
		chk1(regulator_power_down, 1'b1);
		chk({28'h000_0000, regulator_control_value}, 32'h0000_0005);
		rchk(IDX_REG_CTRL, 16'h0005);
		wr(IDX_REG_CTRL, 16'h000c);
		chk1(regulator_power_down, 1'b0);
		chk({28'h000_0000, regulator_control_value}, 32'h0000_000c);
		bus(1'b0, IDX_FIB_CTRL2, 16'h0000);
		rchk(IDX_FIB_CTRL2, 16'h2d64);
		bus(1'b0, IDX_IRQ_STATUS, 16'h0000);
		wr(IDX_IRQ_MASK, 16'h0001);
		rchk(IDX_IRQ_MASK, 16'h0001);
		fiber_in.pecl_violation <= 1'b1;
		settle();
		fiber_in.pecl_violation <= 1'b0;
		settle();
		chk1(irq, 1'b0);
		rchk(IDX_FIB_CTRL2, 16'h6d64);
		rchk(IDX_FIB_CTRL2, 16'h2d64);
		fiber_in.fef <= 1'b1;
		settle();
		fiber_in.fef <= 1'b0;
		settle();
		chk1(irq, 1'b1);
		rchk(IDX_FIB_CTRL2, 16'had64);
		rchk(IDX_FIB_CTRL2, 16'h2d64);
		rchk(IDX_IRQ_STATUS, 16'h0003);
		settle();
		chk1(irq, 1'b0);
		rchk(IDX_IRQ_STATUS, 16'h0000);
		fiber_in.signal_detect <= 1'b0;
		settle();
		fiber_in.signal_detect <= 1'b1;
		settle();
		rchk(IDX_FIB_CTRL2, 16'h0d64);
		rchk(IDX_FIB_CTRL2, 16'h2d64);
		rchk(IDX_IRQ_STATUS, 16'h0004);
		fiber_in.signal_detect <= 1'b0;
		fiber_in.valid_signalling <= 1'b1;
		settle();
		chk1(fiber_sd_effective, 1'b0);
		wr(IDX_FIB_CTRL2, 16'h0200);
		settle();
		chk1(fiber_sd_effective, 1'b1);
		rchk(IDX_FIB_CTRL2, 16'h0f64);
		wr(IDX_FIB_MANUAL, 16'h8000);
		settle();
		chk1(fiber_sd_effective, 1'b0);
		rchk(IDX_FIB_MANUAL, 16'h8200);
		fiber_in.valid_signalling <= 1'b0;
		wr(IDX_FIB_MANUAL, 16'hc000);
		settle();
		chk1(fiber_sd_effective, 1'b1);
		wr(IDX_FIB_MANUAL, 16'h0000);
		settle();
		chk1(fiber_sd_effective, 1'b0);
		results();
	end

endmodule
